// ==== src/i2csar_pkg.sv ====
// Constants, carrier types and state layout for the status and abort reporting block.
package i2csar_pkg;

    // ------------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------------
    localparam int          ADDR_W     = 32;
    localparam int          DATA_W     = 32;
    localparam int          REG_W      = 16;
    localparam int          LVL_W      = 6;
    localparam logic [5:0]  FIFO_DEPTH = 6'h20;
    localparam logic [5:0]  LVL_ONE    = 6'h01;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam logic [1:0]  EN_DELAY   = 2'h2;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] OFF_CON       = 32'h5000_1300;
    localparam logic [31:0] OFF_DATA_CMD  = 32'h5000_1310;
    localparam logic [31:0] OFF_CLR_ABORT = 32'h5000_1354;
    localparam logic [31:0] OFF_ENABLE    = 32'h5000_136C;
    localparam logic [31:0] OFF_STATUS    = 32'h5000_1370;
    localparam logic [31:0] OFF_TX_FILL   = 32'h5000_1374;
    localparam logic [31:0] OFF_RX_FILL   = 32'h5000_1378;
    localparam logic [31:0] OFF_HOLD      = 32'h5000_137C;
    localparam logic [31:0] OFF_ABORT     = 32'h5000_1380;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int STS_SLAVE_BUSY  = 6;
    localparam int STS_MASTER_BUSY = 5;
    localparam int STS_RX_FULL     = 4;
    localparam int STS_RX_HAS_DATA = 3;
    localparam int STS_TX_EMPTY    = 2;
    localparam int STS_TX_HAS_ROOM = 1;
    localparam int STS_ACTIVITY    = 0;
    localparam int AB_SLV_RD_CMD   = 15;
    localparam int AB_SLV_BUS_LOSS = 14;
    localparam int AB_SLV_FLUSH    = 13;
    localparam int AB_ARB_LOSS     = 12;
    localparam int AB_MASTER_DIS   = 11;
    localparam int AB_LONG_RD_NORS = 10;
    localparam int CMD_READ_BIT    = 8;
    localparam int CON_MASTER_EN   = 0;
    localparam int CON_LONG_ADDR   = 4;
    localparam int CON_RESTART_EN  = 5;
    localparam int ENABLE_BIT      = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] HOLD_RST  = 16'h0001;
    localparam logic [15:0] CON_RST   = 16'h0021;
    localparam logic [15:0] ABORT_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } i2csar_req_t;

    typedef struct packed {
        logic [31:0] rd_data;
        logic [5:0]  tx_lvl;
        logic [5:0]  rx_lvl;
        logic [15:0] hold;
        logic [15:0] abort;
        logic [15:0] con;
        logic        enable;
        logic [1:0]  en_pipe;
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_d;
        logic        sda_s1;
        logic        sda_s2;
        logic [15:0] hold_cnt;
        logic        hold_busy;
        logic        sda_update;
        logic        abort_irq;
    } i2csar_state_t;

endpackage

// ==== src/i2csar_top.sv ====
// Status, fill-level, hold-time and transmit-abort reporting for the two-wire bus controller.
//
// Functional notes
// - Slave busy bit 6 follows the slave state machine being away from idle.
// - Master busy bit 5 follows the master state machine being away from idle.
// - Receive full bit 4 is high exactly when every receive location is used.
// - Receive has-data bit 3 is high while the receive buffer is not empty.
// - Transmit empty bit 2 resets high, tracks emptiness, never raises an interrupt.
// - Transmit has-room bit 1 resets high, cleared only when transmit buffer is full.
// - Overall activity bit 0 is read-only and zero after reset.
// - Transmit fill count is read in bits 5 to 0.
// - Receive fill count is read in bits 5 to 0.
// - Read command written while answering a slave data request sets abort bit 15.
// - Slave losing the bus while sending sets abort bits 14 and 12 together.
// - While sending, data line is compared at each clock rise; mismatch means loss.
// - Slave read request with stale transmit data sets bit 13, raises abort, flushes.
// - Master arbitration loss sets bit 12; slave transmitter loss also sets it.
// - Master and slave reporting work independently and at the same time.
// - Master transfer requested while master function disabled sets abort bit 11.
// - Long-address read with repeated start disallowed sets abort bit 10.
// - Disabling the controller flushes both buffers, counts go to zero.
`timescale 1ns/1ns

module i2csar_top (
    input  wire logic                 sys_clk,             // Controller clock, 25 MHz.
    input  wire logic                 rst,                 // Asynchronous reset, active high.
    input  wire i2csar_pkg::i2csar_req_t reg_req,          // Register bus request.
    output logic [31:0]               reg_rd_data,         // Read data, cycle after read strobe.
    input  wire logic                 slave_fsm_busy,      // Slave state machine not idle.
    input  wire logic                 master_fsm_busy,     // Master state machine not idle.
    input  wire logic                 slave_tx_active,     // Slave is shifting data out.
    input  wire logic                 master_tx_active,    // Master is shifting data out.
    input  wire logic                 sda_drive_bit,       // Bit currently driven on data line.
    input  wire logic                 slave_read_request,  // Pulse: remote master asks to read.
    input  wire logic                 slave_rd_req_pending, // Level: slave data request open.
    input  wire logic                 tx_pop,              // Pulse: shifter took a transmit entry.
    input  wire logic                 rx_push,             // Pulse: received byte stored.
    input  wire logic [7:0]           rx_byte,             // Oldest received byte.
    input  wire logic                 scl_in,              // Clock line level from pin.
    input  wire logic                 sda_in,              // Data line level from pin.
    output logic                      sda_update,          // Pulse: data line may change now.
    output logic                      transmit_abort_irq,  // Level: abort record not empty.
    output logic                      ctrl_enabled,        // Controller enable after delay.
    output logic                      master_enable,       // Master function allowed.
    output logic                      repeated_start_allow, // Repeated start allowed.
    output logic                      long_addr_mode,      // Ten-bit master addressing.
    output logic                      tx_has_room_flag     // Transmit buffer can take a write.
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [5:0] lvl_next(input logic [5:0] lvl,
                                            input logic       push,
                                            input logic       pop);
        logic [5:0] res;
        res = lvl;
        if (push && !pop) begin
            res = 6'(lvl + i2csar_pkg::LVL_ONE);
        end else if (pop && !push) begin
            res = 6'(lvl - i2csar_pkg::LVL_ONE);
        end
        return res;
    endfunction

    function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
        return addr == off;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    i2csar_pkg::i2csar_state_t state_ff;
    i2csar_pkg::i2csar_state_t nxt_state;

    logic [15:0] status_word;
    logic [15:0] abort_events;
    logic        tx_full;
    logic        rx_full;
    logic        tx_empty;
    logic        rx_empty;
    logic        scl_rise;
    logic        scl_fall;
    logic        line_mismatch;
    logic        wr_data_cmd;
    logic        rd_data_cmd;
    logic        cmd_is_read;
    logic        clr_abort;
    logic        tx_push;
    logic        tx_take;
    logic        rx_store;
    logic        rx_take;
    logic        stale_flush;

    // ------------------------------------------------------------------
    // Status and event decode
    // ------------------------------------------------------------------
    always_comb begin
        tx_full  = state_ff.tx_lvl == i2csar_pkg::FIFO_DEPTH;
        rx_full  = state_ff.rx_lvl == i2csar_pkg::FIFO_DEPTH;
        tx_empty = state_ff.tx_lvl == 6'h00;
        rx_empty = state_ff.rx_lvl == 6'h00;

        // Only the second synchroniser stage and its delayed copy feed edge logic.
        scl_rise = state_ff.scl_s2 && !state_ff.scl_d;
        scl_fall = !state_ff.scl_s2 && state_ff.scl_d;
        line_mismatch = scl_rise && (state_ff.sda_s2 != sda_drive_bit);

        wr_data_cmd = reg_req.wr && hit(reg_req.addr, i2csar_pkg::OFF_DATA_CMD);
        rd_data_cmd = reg_req.rd && hit(reg_req.addr, i2csar_pkg::OFF_DATA_CMD);
        cmd_is_read = reg_req.wdata[i2csar_pkg::CMD_READ_BIT];
        clr_abort   = reg_req.rd && hit(reg_req.addr, i2csar_pkg::OFF_CLR_ABORT);

        stale_flush = slave_read_request && !tx_empty;

        status_word = 16'h0000;
        status_word[i2csar_pkg::STS_SLAVE_BUSY]  = slave_fsm_busy;
        status_word[i2csar_pkg::STS_MASTER_BUSY] = master_fsm_busy;
        status_word[i2csar_pkg::STS_RX_FULL]     = rx_full;
        status_word[i2csar_pkg::STS_RX_HAS_DATA] = !rx_empty;
        status_word[i2csar_pkg::STS_TX_EMPTY]    = tx_empty;
        status_word[i2csar_pkg::STS_TX_HAS_ROOM] = !tx_full;
        // Both roles feed the activity bit so either one alone marks the block active.
        status_word[i2csar_pkg::STS_ACTIVITY] = slave_fsm_busy || master_fsm_busy
                                                || !tx_empty;

        abort_events = 16'h0000;
        abort_events[i2csar_pkg::AB_SLV_RD_CMD] = wr_data_cmd && cmd_is_read
                                                  && slave_rd_req_pending;
        abort_events[i2csar_pkg::AB_SLV_BUS_LOSS] = slave_tx_active && line_mismatch;
        abort_events[i2csar_pkg::AB_SLV_FLUSH]    = stale_flush;
        // Master and slave losses are checked side by side; both may land at once.
        abort_events[i2csar_pkg::AB_ARB_LOSS] = (master_tx_active || slave_tx_active)
                                                && line_mismatch;
        abort_events[i2csar_pkg::AB_MASTER_DIS] = wr_data_cmd
                                                  && !state_ff.con[i2csar_pkg::CON_MASTER_EN];
        abort_events[i2csar_pkg::AB_LONG_RD_NORS] = wr_data_cmd && cmd_is_read
            && state_ff.con[i2csar_pkg::CON_MASTER_EN]
            && state_ff.con[i2csar_pkg::CON_LONG_ADDR]
            && !state_ff.con[i2csar_pkg::CON_RESTART_EN];

        // A write that the buffer cannot hold is dropped rather than overwriting data.
        tx_push  = wr_data_cmd && !tx_full && state_ff.enable;
        tx_take  = tx_pop && !tx_empty;
        rx_store = rx_push && !rx_full && state_ff.enable;
        rx_take  = rd_data_cmd && !rx_empty;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rd_data    = 32'h0000_0000;
        nxt_state.sda_update = 1'b0;

        // Two-stage synchronisers on the bus lines.
        nxt_state.scl_s1 = scl_in;
        nxt_state.scl_s2 = state_ff.scl_s1;
        nxt_state.scl_d  = state_ff.scl_s2;
        nxt_state.sda_s1 = sda_in;
        nxt_state.sda_s2 = state_ff.sda_s1;

        // Fill levels.
        nxt_state.tx_lvl = lvl_next(state_ff.tx_lvl, tx_push, tx_take);
        nxt_state.rx_lvl = lvl_next(state_ff.rx_lvl, rx_store, rx_take);
        if (stale_flush) begin
            nxt_state.tx_lvl = 6'h00;
        end
        if (!state_ff.enable) begin
            nxt_state.tx_lvl = 6'h00;
            nxt_state.rx_lvl = 6'h00;
        end

        // Abort record: a new event in the clearing cycle survives the clear.
        if (clr_abort) begin
            nxt_state.abort = abort_events;
        end else begin
            nxt_state.abort = state_ff.abort | abort_events;
        end
        nxt_state.abort_irq = |nxt_state.abort;

        // The enable takes effect after a short delay, as the datapath expects.
        nxt_state.en_pipe = {state_ff.en_pipe[0], state_ff.enable};

        // Hold timer: a setting of zero behaves as one so data never moves on the edge.
        if (scl_fall) begin
            nxt_state.hold_busy = 1'b1;
            nxt_state.hold_cnt  = (state_ff.hold == 16'h0000) ? i2csar_pkg::CNT_ONE
                                                              : state_ff.hold;
        end else if (state_ff.hold_busy) begin
            if (state_ff.hold_cnt == i2csar_pkg::CNT_ONE) begin
                nxt_state.hold_busy  = 1'b0;
                nxt_state.sda_update = 1'b1;
            end else begin
                nxt_state.hold_cnt = 16'(state_ff.hold_cnt - i2csar_pkg::CNT_ONE);
            end
        end

        // Register writes.
        if (reg_req.wr) begin
            if (hit(reg_req.addr, i2csar_pkg::OFF_HOLD)) begin
                nxt_state.hold = reg_req.wdata[15:0];
            end
            if (hit(reg_req.addr, i2csar_pkg::OFF_CON)) begin
                nxt_state.con = reg_req.wdata[15:0];
            end
            if (hit(reg_req.addr, i2csar_pkg::OFF_ENABLE)) begin
                nxt_state.enable = reg_req.wdata[i2csar_pkg::ENABLE_BIT];
            end
        end

        // Register reads; unmapped addresses read as zero.
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                i2csar_pkg::OFF_STATUS: begin
                    nxt_state.rd_data = {16'h0000, status_word};
                end
                i2csar_pkg::OFF_TX_FILL: begin
                    nxt_state.rd_data = {26'h0000000, state_ff.tx_lvl};
                end
                i2csar_pkg::OFF_RX_FILL: begin
                    nxt_state.rd_data = {26'h0000000, state_ff.rx_lvl};
                end
                i2csar_pkg::OFF_HOLD: begin
                    nxt_state.rd_data = {16'h0000, state_ff.hold};
                end
                i2csar_pkg::OFF_ABORT: begin
                    nxt_state.rd_data = {16'h0000, state_ff.abort};
                end
                i2csar_pkg::OFF_CON: begin
                    nxt_state.rd_data = {16'h0000, state_ff.con};
                end
                i2csar_pkg::OFF_ENABLE: begin
                    nxt_state.rd_data = {31'h00000000, state_ff.enable};
                end
                i2csar_pkg::OFF_DATA_CMD: begin
                    nxt_state.rd_data = {24'h000000, rx_byte};
                end
                i2csar_pkg::OFF_CLR_ABORT: begin
                    nxt_state.rd_data = {31'h00000000, |state_ff.abort};
                end
                default: begin
                    nxt_state.rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff.rd_data    <= 32'h0000_0000;
            state_ff.tx_lvl     <= 6'h00;
            state_ff.rx_lvl     <= 6'h00;
            state_ff.hold       <= i2csar_pkg::HOLD_RST;
            state_ff.abort      <= i2csar_pkg::ABORT_RST;
            state_ff.con        <= i2csar_pkg::CON_RST;
            state_ff.enable     <= 1'b0;
            state_ff.en_pipe    <= 2'h0;
            state_ff.scl_s1     <= 1'b1;
            state_ff.scl_s2     <= 1'b1;
            state_ff.scl_d      <= 1'b1;
            state_ff.sda_s1     <= 1'b1;
            state_ff.sda_s2     <= 1'b1;
            state_ff.hold_cnt   <= 16'h0000;
            state_ff.hold_busy  <= 1'b0;
            state_ff.sda_update <= 1'b0;
            state_ff.abort_irq  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rd_data          = state_ff.rd_data;
    assign sda_update           = state_ff.sda_update;
    assign transmit_abort_irq   = state_ff.abort_irq;
    assign ctrl_enabled         = state_ff.en_pipe[1];
    assign master_enable        = state_ff.con[i2csar_pkg::CON_MASTER_EN];
    assign repeated_start_allow = state_ff.con[i2csar_pkg::CON_RESTART_EN];
    assign long_addr_mode       = state_ff.con[i2csar_pkg::CON_LONG_ADDR];
    assign tx_has_room_flag     = !tx_full && state_ff.enable;

endmodule

// ==== sim/i2csar_props.sv ====
// Port-level concurrent checks for the status and abort reporting block.
`timescale 1ns/1ns
module i2csar_props (
    input wire logic                    sys_clk,              // Controller clock.
    input wire logic                    rst,                  // Asynchronous reset.
    input wire i2csar_pkg::i2csar_req_t reg_req,              // Register request.
    input wire logic [31:0]             reg_rd_data,          // Read data.
    input wire logic                    slave_fsm_busy,       // Slave machine busy.
    input wire logic                    master_fsm_busy,      // Master machine busy.
    input wire logic                    slave_rd_req_pending, // Slave request open.
    input wire logic                    transmit_abort_irq,   // Abort record not empty.
    input wire logic                    master_enable,        // Master allowed.
    input wire logic                    repeated_start_allow, // Restart allowed.
    input wire logic                    long_addr_mode        // Ten-bit mode.
);
    // ----------
    // Decoded requests
    // ----------
    logic sts_rd;
    logic dc_wr;
    logic clr_rd;
    assign sts_rd = reg_req.rd && reg_req.addr == i2csar_pkg::OFF_STATUS;
    assign dc_wr  = reg_req.wr && reg_req.addr == i2csar_pkg::OFF_DATA_CMD;
    assign clr_rd = reg_req.rd && reg_req.addr == i2csar_pkg::OFF_CLR_ABORT;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_rd_idle; !$past(reg_req.rd) |-> reg_rd_data == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    property p_rd_upper; $past(reg_req.rd) |-> reg_rd_data[31:16] == 16'h0000; endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
    property p_sts_slave; $past(sts_rd) |-> reg_rd_data[6] == $past(slave_fsm_busy); endproperty
    a_sts_slave: assert property (p_sts_slave) else $error("slave busy bit wrong");
    property p_sts_master;
        $past(sts_rd) |-> reg_rd_data[5] == $past(master_fsm_busy);
    endproperty
    a_sts_master: assert property (p_sts_master) else $error("master busy bit wrong");
    property p_abt_slv_rd; dc_wr && reg_req.wdata[8] && slave_rd_req_pending |=> transmit_abort_irq;
    endproperty
    a_abt_slv_rd: assert property (p_abt_slv_rd) else $error("slave read abort missing");
    property p_abt_mdis; dc_wr && !master_enable |=> transmit_abort_irq; endproperty
    a_abt_mdis: assert property (p_abt_mdis) else $error("master disabled abort missing");
    sequence s_long_rd;
        dc_wr && reg_req.wdata[8] && master_enable && long_addr_mode && !repeated_start_allow;
    endsequence
    property p_abt_long; s_long_rd |=> transmit_abort_irq; endproperty
    a_abt_long: assert property (p_abt_long) else $error("long read abort missing");
    property p_abt_keep; transmit_abort_irq && !clr_rd |=> transmit_abort_irq; endproperty
    a_abt_keep: assert property (p_abt_keep) else $error("abort dropped without clear");
    property p_abt_clr; clr_rd && !slave_rd_req_pending |=> ##[0:1] !transmit_abort_irq; endproperty
    a_abt_clr: assert property (p_abt_clr) else $error("abort not cleared");
    c_slv_rd: cover property (dc_wr && slave_rd_req_pending);
    c_clr: cover property (clr_rd && transmit_abort_irq);
    c_both: cover property (slave_fsm_busy && master_fsm_busy);
endmodule

bind i2csar_top i2csar_props u_props (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
    .slave_fsm_busy(slave_fsm_busy), .master_fsm_busy(master_fsm_busy),
    .slave_rd_req_pending(slave_rd_req_pending), .transmit_abort_irq(transmit_abort_irq),
    .master_enable(master_enable), .repeated_start_allow(repeated_start_allow),
    .long_addr_mode(long_addr_mode));

// ==== sim/i2csar_far_end.sv ====
// Behavioural far-end bus party driving the clock and data lines.
`timescale 1ns/1ns
module i2csar_far_end (
    output logic scl, // Clock line level.
    output logic sda  // Data line level.
);
    // Both lines have pull-ups, so a released line reads high.
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // One bit cell; data is released while the clock is low again.
    task automatic bit_cell(input logic d);
        #5 scl = 1'b0;
        #400 sda = d;
        #400 scl = 1'b1;
        #400 scl = 1'b0;
        sda = 1'b1;
        #400 scl = 1'b1;
    endtask
endmodule

// ==== sim/test_i2csar_top.sv ====
// Self-checking bench for the status and abort reporting block.
`timescale 1ns/1ns
module test_i2csar_top;
    localparam logic [31:0]  STS = i2csar_pkg::OFF_STATUS, TXF = i2csar_pkg::OFF_TX_FILL;
    localparam logic [31:0]  RXF = i2csar_pkg::OFF_RX_FILL, ABT = i2csar_pkg::OFF_ABORT;
    localparam logic [31:0]  CLR = i2csar_pkg::OFF_CLR_ABORT, DC = i2csar_pkg::OFF_DATA_CMD;
    logic                    sys_clk = 1'b0;
    logic                    rst = 1'b1;
    i2csar_pkg::i2csar_req_t req = '0;
    logic [31:0]             rdata;
    logic                    s_busy = 1'b0, m_busy = 1'b0, s_tx = 1'b0, m_tx = 1'b0;
    logic                    srq = 1'b0, pend = 1'b0, tx_pop = 1'b0, rx_push = 1'b0;
    logic                    rd_q = 1'b0, drv = 1'b1, scl, sda, sda_upd, room, ce;
    logic [7:0]              rx_byte = 8'h00;
    logic [31:0]             exp_q[$], msk_q[$], adr_q[$], e, m;
    logic [31:0]             abt[3] = '{32'h5000, 32'h1000, 32'h0000};
    logic [31:0]             cv[3] = '{32'h21, 32'h20, 32'h11};
    logic [31:0]             dv[3] = '{32'h100, 32'h000, 32'h100};
    logic [31:0]             av[3] = '{32'h8000, 32'h0800, 32'h0400};
    int                      errors = 0, checked = 0, cycles = 0, h, n, cnt;
    always #20 sys_clk = ~sys_clk;
    i2csar_far_end far (.scl(scl), .sda(sda));
    i2csar_top uut (.sys_clk(sys_clk), .rst(rst), .reg_req(req), .reg_rd_data(rdata),
        .slave_fsm_busy(s_busy), .master_fsm_busy(m_busy), .slave_tx_active(s_tx),
        .master_tx_active(m_tx), .sda_drive_bit(drv), .slave_read_request(srq),
        .slave_rd_req_pending(pend), .tx_pop(tx_pop), .rx_push(rx_push), .rx_byte(rx_byte),
        .scl_in(scl), .sda_in(sda), .sda_update(sda_upd), .transmit_abort_irq(),
        .ctrl_enabled(ce), .master_enable(), .repeated_start_allow(), .long_addr_mode(),
        .tx_has_room_flag(room));
    // ----------
    // Bus tasks, result monitor and closing report
    // ----------
    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        checked++;
        if (sn !== ex) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, sn);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, ex, mk = 32'hFFFF_FFFF);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        adr_q.push_back(a);
        @(posedge sys_clk);
        req.rd <= 1'b0;
    endtask
    // Raises rx_push, tx_pop or srq (w = 0, 1, 2) for k edges.
    task automatic pulse(input int w, input int k);
        @(posedge sys_clk);
        {rx_push, tx_pop, srq} <= 3'b100 >> w;
        repeat (k) @(posedge sys_clk);
        {rx_push, tx_pop, srq} <= 3'b000;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) rd_q <= req.rd;
    always @(negedge sys_clk) begin
        if (rd_q) begin
            m = msk_q.pop_front();
            cmp($sformatf("read %h", adr_q.pop_front()), exp_q.pop_front() & m, rdata & m);
        end
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        void'($urandom(76240));
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(STS, 32'h6);
        rd(TXF, 32'h0);
        rd(RXF, 32'h0);
        rd(i2csar_pkg::OFF_HOLD, 32'h1);
        rd(ABT, 32'h0);
        rd(32'h5000_1390, 32'h0);
        wr(STS, 32'hFFFF);
        rd(STS, 32'h6);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            {s_busy, m_busy} <= 2'(i);
            rd(STS, 32'({2'(i), 5'h06}) | 32'(i != 0));
        end
        {s_busy, m_busy} <= 2'b00;
        $display("test reset and activity done");
        h = $urandom_range(12, 3);
        wr(i2csar_pkg::OFF_HOLD, 32'(h));
        rd(i2csar_pkg::OFF_HOLD, 32'(h));
        fork
            far.bit_cell(1'b1);
            begin
                cnt = 0;
                @(negedge sys_clk);
                while (sda_upd !== 1'b1 && cnt < 40) begin
                    @(negedge sys_clk);
                    cnt++;
                end
            end
        join
        cmp("hold delay", 32'h1, 32'(cnt == h + 3));
        $display("test hold done");
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            {s_tx, m_tx} <= (i == 1) ? 2'b01 : 2'b10;
            drv <= (i == 0);
            far.bit_cell(i == 1);
            {s_tx, m_tx} <= 2'b00;
            rd(ABT, abt[i]);
            rd(CLR, 32'(abt[i] != 0));
        end
        $display("test arbitration done");
        wr(i2csar_pkg::OFF_ENABLE, 32'h1);
        repeat (2) @(negedge sys_clk);
        cmp("ctrl enabled", 32'h0, 32'(ce));
        @(negedge sys_clk);
        cmp("ctrl enabled", 32'h1, 32'(ce));
        n = $urandom_range(6, 2);
        repeat (n) wr(DC, 32'($urandom_range(255, 0)));
        rd(TXF, 32'(n));
        rd(STS, 32'h3, 32'h7);
        pulse(1, 1);
        rd(TXF, 32'(n - 1));
        pulse(2, 1);
        rd(ABT, 32'h2000);
        rd(TXF, 32'h0);
        rd(CLR, 32'h1);
        n = $urandom_range(5, 1);
        pulse(0, n);
        rd(RXF, 32'(n));
        rd(STS, 32'h08, 32'h18);
        pulse(0, 40);
        rd(RXF, 32'h20);
        rd(STS, 32'h18, 32'h18);
        e = 32'($urandom_range(255, 0));
        rx_byte <= e[7:0];
        rd(DC, e, 32'hFF);
        rd(RXF, 32'h1F);
        rd(STS, 32'h08, 32'h18);
        repeat (32) wr(DC, 32'h0);
        rd(STS, 32'h0, 32'h6);
        rd(TXF, 32'h20);
        @(negedge sys_clk);
        cmp("tx room", 32'h0, 32'(room));
        wr(i2csar_pkg::OFF_ENABLE, 32'h0);
        rd(TXF, 32'h0);
        rd(RXF, 32'h0);
        rd(STS, 32'h6);
        $display("test levels done");
        for (int i = 0; i < 3; i++) begin
            wr(i2csar_pkg::OFF_CON, cv[i]);
            @(posedge sys_clk);
            pend <= (i == 0);
            wr(DC, dv[i]);
            rd(ABT, av[i]);
            rd(CLR, 32'h1);
        end
        $display("test abort causes done");
        repeat (3) @(posedge sys_clk);
        test_done();
    end
endmodule
